// *** ptg_defines.vh ***
// ptg_defines.vh: constants for the three-generator pwm unit
// assumes inclusion by ptg_unit.v only; no timing in absolute units needed
`ifndef PTG_DEFINES_VH
`define PTG_DEFINES_VH
`define PTG_NUM_GEN     3
`define PTG_CNT_W       16
`define PTG_EV_ZERO     0
`define PTG_EV_LOAD     1
`define PTG_EV_CMP1_UP  2
`define PTG_EV_CMP1_DN  3
`define PTG_EV_CMP2_UP  4
`define PTG_EV_CMP2_DN  5
`define PTG_EV_W        6
`endif

// *** ptg_unit.v ***
// ptg_unit.v: three pwm generators with dead band and an output control block
// assumes all inputs synchronous to mclk_in; config buses packed per generator
`timescale 1ns/1ps
`include "ptg_defines.vh"
module ptg_unit #(
    parameter CW = `PTG_CNT_W,
    parameter NG = `PTG_NUM_GEN
) (
    input  wire            mclk_in,
    input  wire            rst_in,
    input  wire [NG-1:0]   gen_enable_in,
    input  wire [NG-1:0]   up_down_mode_in,
    input  wire [NG-1:0]   sync_mode_in,
    input  wire [NG-1:0]   debug_pause_in,
    input  wire            debug_halt_in,
    input  wire [NG-1:0]   sync_update_in,
    input  wire [NG*CW-1:0] load_value_in,
    input  wire [NG*CW-1:0] cmp_first_in,
    input  wire [NG*CW-1:0] cmp_second_in,
    input  wire [NG-1:0]   dead_band_en_in,
    input  wire [NG*CW-1:0] rise_delay_count_in,
    input  wire [NG*CW-1:0] fall_delay_count_in,
    input  wire [NG*`PTG_EV_W-1:0] int_event_en_in,
    input  wire [NG*`PTG_EV_W-1:0] trig_event_en_in,
    input  wire [2*NG-1:0] output_invert_in,
    input  wire [2*NG-1:0] output_pass_in,
    output wire [2*NG-1:0] unit_output_out,
    output wire [NG-1:0]   gen_int_out,
    output wire [NG-1:0]   gen_trigger_out,
    output wire [NG*CW-1:0] gen_count_out
);
    localparam [CW-1:0] CNT_ZERO = {CW{1'b0}};
    localparam [CW-1:0] CNT_ONE  = {{(CW-1){1'b0}}, 1'b1};
    localparam [CW-1:0] CNT_MAX  = {CW{1'b1}};

    // compare hit split by count direction; both comparators share it
    function [1:0] side_hit;
        input [CW-1:0] count;
        input [CW-1:0] level;
        input          up;
        input          live;
        begin
            side_hit[0] = live & (count == level) & up;
            side_hit[1] = live & (count == level) & ~up;
        end
    endfunction

    // level after one edge: down mode is high from zero to compare,
    // up/down is low from zero and high from the down-count compare hit until zero
    function next_level;
        input hit_up;
        input hit_dn;
        input zero_hit;
        input centre;
        input level;
        begin
            if (hit_up | hit_dn)
                next_level = centre ? hit_dn : 1'b0;
            else if (zero_hit)
                next_level = ~centre;
            else
                next_level = level;
        end
    endfunction

    // one generator per slice; output bit 2g is the first output, 2g+1 the second
    genvar g;
    generate
        for (g = 0; g < NG; g = g + 1) begin : gen_slice
            reg  [CW-1:0] cnt;
            reg           dir_up;
            reg  [CW-1:0] act_load;
            reg  [CW-1:0] act_cmp1;
            reg  [CW-1:0] act_cmp2;
            reg           sync_pend;
            reg           first_raw;
            reg           second_raw;
            reg           first_q;
            reg  [CW-1:0] db_age;
            reg           db_last;
            reg           pin_first;
            reg           pin_second;
            reg           int_q;
            reg           trig_q;
            reg  [CW-1:0] count_q;
            wire [CW-1:0] ld   = load_value_in[g*CW +: CW];
            wire [CW-1:0] c1   = cmp_first_in[g*CW +: CW];
            wire [CW-1:0] c2   = cmp_second_in[g*CW +: CW];
            wire [CW-1:0] rise = rise_delay_count_in[g*CW +: CW];
            wire [CW-1:0] fall = fall_delay_count_in[g*CW +: CW];
            wire [`PTG_EV_W-1:0] ien = int_event_en_in[g*`PTG_EV_W +: `PTG_EV_W];
            wire [`PTG_EV_W-1:0] ten = trig_event_en_in[g*`PTG_EV_W +: `PTG_EV_W];

            wire          at_zero = (cnt == CNT_ZERO);
            wire          at_load = (cnt == act_load);
            // pause only once the count has come back to zero
            wire          halted  = debug_pause_in[g] & debug_halt_in & at_zero;
            wire          run     = gen_enable_in[g] & ~halted;
            wire [1:0]    hit1    = side_hit(cnt, act_cmp1, dir_up, run);
            wire [1:0]    hit2    = side_hit(cnt, act_cmp2, dir_up, run);
            wire [`PTG_EV_W-1:0] ev;
            assign ev[`PTG_EV_ZERO]    = run & at_zero;
            assign ev[`PTG_EV_LOAD]    = run & at_load;
            assign ev[`PTG_EV_CMP1_UP] = hit1[0];
            assign ev[`PTG_EV_CMP1_DN] = hit1[1];
            assign ev[`PTG_EV_CMP2_UP] = hit2[0];
            assign ev[`PTG_EV_CMP2_DN] = hit2[1];
            // new values only at zero so no pulse is cut short or stretched
            wire          apply = at_zero & (~sync_mode_in[g] | sync_pend);

            // a new sync request wins over the clear on apply
            always @(posedge mclk_in or posedge rst_in) begin
                if (rst_in) begin
                    sync_pend <= 1'b0;
                end else if (sync_update_in[g]) begin
                    sync_pend <= 1'b1;
                end else if (apply) begin
                    sync_pend <= 1'b0;
                end
            end

            always @(posedge mclk_in or posedge rst_in) begin
                if (rst_in) begin
                    act_load <= CNT_ZERO;
                    act_cmp1 <= CNT_ZERO;
                    act_cmp2 <= CNT_ZERO;
                end else if (apply) begin
                    act_load <= ld;
                    act_cmp1 <= c1;
                    act_cmp2 <= c2;
                end
            end

            always @(posedge mclk_in or posedge rst_in) begin
                if (rst_in) begin
                    cnt    <= CNT_ZERO;
                    dir_up <= 1'b1;
                end else if (!gen_enable_in[g]) begin
                    cnt    <= CNT_ZERO;
                    dir_up <= 1'b1;
                end else if (run) begin
                    if (up_down_mode_in[g]) begin
                        if (at_zero) begin
                            cnt    <= CNT_ONE;
                            dir_up <= 1'b1;
                        end else if (dir_up && cnt >= act_load) begin
                            cnt    <= cnt - CNT_ONE;
                            dir_up <= 1'b0;
                        end else if (dir_up) begin
                            cnt <= cnt + CNT_ONE;
                        end else begin
                            cnt <= cnt - CNT_ONE;
                        end
                    end else begin
                        dir_up <= 1'b0;
                        if (at_zero)
                            cnt <= apply ? ld : act_load;
                        else
                            cnt <= cnt - CNT_ONE;
                    end
                end
            end

            // waveform: down mode high from zero, low at compare; up/down high from the down-count hit to zero
            always @(posedge mclk_in or posedge rst_in) begin
                if (rst_in) begin
                    first_raw  <= 1'b0;
                    second_raw <= 1'b0;
                end else if (!gen_enable_in[g]) begin
                    first_raw  <= 1'b0;
                    second_raw <= 1'b0;
                end else begin
                    first_raw  <= next_level(hit1[0], hit1[1], ev[`PTG_EV_ZERO],
                                             up_down_mode_in[g], first_raw);
                    second_raw <= next_level(hit2[0], hit2[1], ev[`PTG_EV_ZERO],
                                             up_down_mode_in[g], second_raw);
                end
            end

            // dead band: age counts cycles since the first output last changed
            wire          first_moved = first_raw ^ first_q;
            wire [CW-1:0] age_now     = first_moved ? CNT_ZERO : db_age;
            wire          db_pair     = first_raw ? (age_now >= rise)
                                                  : (db_last & (age_now < fall));

            always @(posedge mclk_in or posedge rst_in) begin
                if (rst_in) begin
                    first_q <= 1'b0;
                    db_age  <= CNT_ZERO;
                    db_last <= 1'b0;
                end else begin
                    first_q <= first_raw;
                    db_last <= db_pair;
                    if (first_moved)
                        db_age <= CNT_ONE;
                    else if (db_age != CNT_MAX)
                        db_age <= db_age + CNT_ONE;
                end
            end

            // polarity and gating in the control block, registered to the pins
            wire out_a = first_raw;
            wire out_b = dead_band_en_in[g] ? db_pair
                                            : second_raw;
            always @(posedge mclk_in or posedge rst_in) begin
                if (rst_in) begin
                    pin_first  <= 1'b0;
                    pin_second <= 1'b0;
                    int_q      <= 1'b0;
                    trig_q     <= 1'b0;
                    count_q    <= CNT_ZERO;
                end else begin
                    pin_first  <= output_pass_in[2*g] &
                                  (out_a ^ output_invert_in[2*g]);
                    pin_second <= output_pass_in[2*g+1] &
                                  (out_b ^ output_invert_in[2*g+1]);
                    int_q      <= |(ev & ien);
                    trig_q     <= |(ev & ten);
                    count_q    <= cnt;
                end
            end

            assign unit_output_out[2*g]      = pin_first;
            assign unit_output_out[2*g+1]    = pin_second;
            assign gen_int_out[g]            = int_q;
            assign gen_trigger_out[g]        = trig_q;
            assign gen_count_out[g*CW +: CW] = count_q;
        end
    endgenerate
endmodule

// *** ptg_load.sv ***
// ptg_load.sv: power stage model that counts high cycles on each unit output
// assumes outputs registered on mclk_in; clear_in restarts every count
`timescale 1ns/1ps
module ptg_load (
    input  wire logic       mclk_in,
    input  wire logic       clear_in,
    input  wire logic [5:0] drive_in,
    output logic      [7:0] high_cycles_out [6]
);
    // a passive load: it only listens, so it never loads the outputs wrongly
    always @(posedge mclk_in) begin
        for (int i = 0; i < 6; i++) begin
            high_cycles_out[i] <= clear_in ? 8'h00 : high_cycles_out[i] + {7'h00, drive_in[i]};
        end
    end
endmodule

// *** ptg_checker.sv ***
// ptg_checker.sv: port assertions for the pwm unit
// assumes binding to ptg_unit; count output lags the counter by one cycle
`timescale 1ns/1ps
module ptg_checker #(
    parameter CW = 16,
    parameter NG = 3
) (
    input wire mclk_in,
    input wire rst_in,
    input wire [NG-1:0] gen_enable_in,
    input wire [NG-1:0] up_down_mode_in,
    input wire [NG-1:0] debug_pause_in,
    input wire debug_halt_in,
    input wire [NG*6-1:0] int_event_en_in,
    input wire [NG*6-1:0] trig_event_en_in,
    input wire [2*NG-1:0] output_pass_in,
    input wire [2*NG-1:0] unit_output_out,
    input wire [NG-1:0] gen_int_out,
    input wire [NG-1:0] gen_trigger_out,
    input wire [NG*CW-1:0] gen_count_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    held_low_a: assert property (($past(~output_pass_in) & $past(~output_pass_in, 2)
        & unit_output_out) == 6'h00) else $error("held output driven high");
    stopped_count_a: assert property (!gen_enable_in[0] ##1 !gen_enable_in[0]
        |=> gen_count_out[15:0] == 16'h0000) else $error("disabled counter moved");
    stopped_pair_a: assert property (!gen_enable_in[1] [*3]
        |=> gen_count_out[31:16] == 16'h0000) else $error("disabled counter moved");
    down_step_a: assert property ($past(gen_enable_in[0] & ~up_down_mode_in[0]
        & ~(debug_halt_in & debug_pause_in[0])) && gen_count_out[15:0] != 16'h0000
        |=> gen_count_out[15:0] == $past(gen_count_out[15:0]) - 16'h0001)
        else $error("down counter step wrong");
    updown_step_a: assert property ($past(gen_enable_in[2] & up_down_mode_in[2]
        & ~(debug_halt_in & debug_pause_in[2])) && gen_count_out[47:32] != 16'h0000
        |=> (gen_count_out[47:32] - $past(gen_count_out[47:32]) == 16'h0001)
        || ($past(gen_count_out[47:32]) - gen_count_out[47:32] == 16'h0001))
        else $error("up/down counter step wrong");
    debug_stop_a: assert property ($past(debug_halt_in & debug_pause_in[0])
        && gen_count_out[15:0] == 16'h0000 |=> gen_count_out[15:0] == 16'h0000)
        else $error("paused counter left zero");
    int_cause_a: assert property (gen_int_out[0] |->
        ($past(int_event_en_in[5:0]) | $past(int_event_en_in[5:0], 2)) != 6'h00)
        else $error("interrupt without enabled event");
    trig_cause_a: assert property (gen_trigger_out[0] |->
        ($past(trig_event_en_in[5:0]) | $past(trig_event_en_in[5:0], 2)) != 6'h00)
        else $error("trigger without enabled event");
endmodule

// *** pwm_three_generator_unit_bench.sv ***
// pwm_three_generator_unit_bench.sv: directed tests of the three-generator pwm unit
// assumes ptg_unit, ptg_load and ptg_checker compiled first
`timescale 1ns/1ps
module pwm_three_generator_unit_bench;
    logic mclk_in = 0, rst_in = 1, debug_halt_in = 0, clr = 0;
    logic [2:0] gen_enable_in = 0, up_down_mode_in = 3'h4, sync_mode_in = 0, debug_pause_in = 0;
    logic [2:0] sync_update_in = 0, dead_band_en_in = 3'h2;
    logic [47:0] load_value_in = 48'h0004_0003_0003, cmp_first_in = 48'h0002_0001_0001;
    logic [47:0] cmp_second_in = 48'h0002_0003_0002, rise_delay_count_in = 48'h0000_0001_0000;
    logic [47:0] fall_delay_count_in = 0;
    logic [17:0] int_event_en_in = 18'h00001, trig_event_en_in = 18'h00008;
    logic [5:0] output_invert_in = 0, output_pass_in = 6'h3F, unit_output_out;
    logic [2:0] gen_int_out, gen_trigger_out;
    logic [47:0] gen_count_out;
    logic [7:0] hc [6];
    logic [15:0] top2;
    int err_count, cmp_count, n_int, n_trg;
    ptg_unit i_dut (.mclk_in, .rst_in, .gen_enable_in, .up_down_mode_in, .sync_mode_in,
        .debug_pause_in, .debug_halt_in, .sync_update_in, .load_value_in, .cmp_first_in,
        .cmp_second_in, .dead_band_en_in, .rise_delay_count_in, .fall_delay_count_in,
        .int_event_en_in, .trig_event_en_in, .output_invert_in, .output_pass_in,
        .unit_output_out, .gen_int_out, .gen_trigger_out, .gen_count_out);
    ptg_load i_load (.mclk_in(mclk_in), .clear_in(clr), .drive_in(unit_output_out),
        .high_cycles_out(hc));
    initial begin
        forever #5 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) begin
        n_int <= clr ? 0 : n_int + gen_int_out[0];
        n_trg <= clr ? 0 : n_trg + gen_trigger_out[0];
        top2 <= clr ? 16'h0000 : (gen_count_out[47:32] > top2 ? gen_count_out[47:32] : top2);
    end
    task automatic chk(input string what, input logic [15:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // whole periods only, so a window of 40 gives exact high counts
    task automatic window;
        clr = 1;
        @(negedge mclk_in) clr = 0;
        repeat (40) @(negedge mclk_in);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge mclk_in);
        rst_in = 0;
        @(negedge mclk_in) gen_enable_in = 3'h7;
        repeat (20) @(negedge mclk_in);
        window;
        chk("out0 high", 16'h001E, hc[0]);
        chk("out1 high", 16'h0014, hc[1]);
        chk("out3 high", 16'h0014, hc[3]);
        chk("int pulses", 16'h000A, n_int[15:0]);
        chk("trigger pulses", 16'h000A, n_trg[15:0]);
        chk("generator_two top", 16'h0004, top2);
        $display("test waveforms done");
        output_invert_in = 6'h01;
        output_pass_in = 6'h3D;
        repeat (4) @(negedge mclk_in);
        window;
        chk("out0 inverted", 16'h000A, hc[0]);
        chk("out1 held", 16'h0000, hc[1]);
        output_invert_in = 0;
        output_pass_in = 6'h3F;
        dead_band_en_in = 0;
        repeat (8) @(negedge mclk_in);
        window;
        chk("out3 own compare", 16'h000A, hc[3]);
        $display("test polarity and dead band done");
        sync_mode_in = 3'h1;
        cmp_first_in[15:0] = 16'h0002;
        repeat (8) @(negedge mclk_in);
        window;
        chk("out0 before sync", 16'h001E, hc[0]);
        sync_update_in = 3'h1;
        @(negedge mclk_in) sync_update_in = 0;
        repeat (10) @(negedge mclk_in);
        window;
        chk("out0 after sync", 16'h0014, hc[0]);
        debug_pause_in = 3'h1;
        debug_halt_in = 1;
        repeat (20) @(negedge mclk_in);
        chk("paused count", 16'h0000, gen_count_out[15:0]);
        debug_halt_in = 0;
        $display("test sync and debug done");
        wrap_up;
    end
    initial begin
        #20000;
        err_count++;
        wrap_up;
    end
endmodule
bind ptg_unit ptg_checker #(.CW(CW), .NG(NG)) i_chk (.mclk_in, .rst_in, .gen_enable_in,
    .up_down_mode_in, .debug_pause_in, .debug_halt_in, .int_event_en_in, .trig_event_en_in,
    .output_pass_in, .unit_output_out, .gen_int_out, .gen_trigger_out, .gen_count_out);
